// File: rtl/meas_pkg.sv
// Package for the phase current and bus voltage measurement block.
// Assumes a 32-bit APB slave with word-aligned registers at index * 4.
package meas_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PHASE_U   = 8'h7a;
  localparam logic [7:0] IDX_PHASE_V   = 8'h7b;
  localparam logic [7:0] IDX_PHASE_W   = 8'h7c;
  localparam logic [7:0] IDX_ALPHA     = 8'h7e;
  localparam logic [7:0] IDX_BETA      = 8'h7f;
  localparam logic [7:0] IDX_VDC_RAW   = 8'h88;
  localparam logic [7:0] IDX_CONFIG    = 8'h90;
  localparam logic [7:0] IDX_OFFSET_U  = 8'h91;
  localparam logic [7:0] IDX_OFFSET_V  = 8'h92;
  localparam logic [7:0] IDX_ADC_GAIN  = 8'h93;
  localparam logic [7:0] IDX_CYCLES    = 8'h94;

  // Field positions and reset values
  localparam int          CFG_SINGLE_BIT = 0;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [11:0] OFFSET_RESET   = 12'h000;
  localparam logic [15:0] GAIN_RESET     = 16'h1000;
  localparam int          GAIN_FRAC      = 12;

  // Result limits in ADC counts
  localparam logic signed [15:0] CUR_MAX = 16'sh07ff;
  localparam logic signed [15:0] CUR_MIN = -16'sh07ff;
  localparam logic [15:0]        VDC_MAX = 16'h0fff;

  // Clarke scaling: 1/sqrt(3) as a Q15 fraction
  localparam logic signed [31:0] INV_SQRT3_Q15 = 32'sh0000_49e7;
  localparam int                 CLARKE_FRAC   = 15;

  // Published measurement results
  typedef struct packed {
    logic signed [15:0] phase_u;
    logic signed [15:0] phase_v;
    logic signed [15:0] phase_w;
    logic signed [15:0] alpha;
    logic signed [15:0] beta;
    logic [15:0]        vdc;
  } results_t;

  // One reconstructed phase pair
  typedef struct packed {
    logic signed [15:0] u;
    logic signed [15:0] v;
  } phase_pair_t;

endpackage : meas_pkg

// File: rtl/phase_meas.sv
// Phase current reconstruction, Clarke transform and bus voltage sampling.
// Assumes ADC samples, sector and the PWM strobe come from logic on REF_CLK_I,
// valid in the cycle in which PWM_SYNC_I is high.
`timescale 1ns/1ps
module phase_meas #(
  parameter int ADC_W = 12  // ADC sample width
) (
  // Clock and reset
  input  wire logic             REF_CLK_I,
  input  wire logic             RST_N_I,
  // APB slave
  input  wire logic             PSEL_I,
  input  wire logic             PENABLE_I,
  input  wire logic             PWRITE_I,
  input  wire logic [11:0]      PADDR_I,
  input  wire logic [31:0]      PWDATA_I,
  output logic      [31:0]      PRDATA_O,
  output logic                  PREADY_O,
  output logic                  PSLVERR_O,
  // ADC samples and PWM timing
  input  wire logic             PWM_SYNC_I,
  input  wire logic [2:0]       SECTOR_I,
  input  wire logic [ADC_W-1:0] SHUNT_A_I,
  input  wire logic [ADC_W-1:0] SHUNT_B_I,
  input  wire logic [ADC_W-1:0] VDC_ADC_I,
  // Result update pulse
  output logic                  RESULT_VALID_O
);

  // Clamp to the published current range
  function automatic logic signed [15:0] sat_cur(input logic signed [31:0] x);
    if (x > 32'(meas_pkg::CUR_MAX)) begin
      sat_cur = meas_pkg::CUR_MAX;
    end else if (x < 32'(meas_pkg::CUR_MIN)) begin
      sat_cur = meas_pkg::CUR_MIN;
    end else begin
      sat_cur = x[15:0];
    end
  endfunction : sat_cur

  // Offset removal and gain compensation of one raw sample
  function automatic logic signed [15:0] compensate(input logic [ADC_W-1:0] raw,
                                                    input logic [11:0]      offs,
                                                    input logic [15:0]      gain);
    logic signed [31:0] diff;
    logic signed [31:0] prod;
    diff = $signed(32'(raw)) - $signed(32'(offs));
    prod = diff * $signed({16'h0000, gain});
    compensate = sat_cur(prod >>> meas_pkg::GAIN_FRAC);
  endfunction : compensate

  // Map the two link samples to phases U and V by PWM sector
  function automatic meas_pkg::phase_pair_t from_link(input logic signed [15:0] a,
                                                      input logic signed [15:0] b,
                                                      input logic [2:0]         sec);
    logic signed [31:0] sa;
    logic signed [31:0] sb;
    sa = 32'(a);
    sb = 32'(b);
    from_link.u = 16'sh0000;
    from_link.v = 16'sh0000;
    unique case (sec)
      3'd1: begin  // A is +U, B is -W
        from_link.u = sat_cur(sa);
        from_link.v = sat_cur(sb - sa);
      end
      3'd2: begin  // A is +V, B is -W
        from_link.u = sat_cur(sb - sa);
        from_link.v = sat_cur(sa);
      end
      3'd3: begin  // A is +V, B is -U
        from_link.u = sat_cur(-sb);
        from_link.v = sat_cur(sa);
      end
      3'd4: begin  // A is +W, B is -U
        from_link.u = sat_cur(-sb);
        from_link.v = sat_cur(sb - sa);
      end
      3'd5: begin  // A is +W, B is -V
        from_link.u = sat_cur(sb - sa);
        from_link.v = sat_cur(-sb);
      end
      3'd6: begin  // A is +U, B is -V
        from_link.u = sat_cur(sa);
        from_link.v = sat_cur(-sb);
      end
      default: begin  // Illegal sector gives zero rather than a wrong phase
        from_link.u = 16'sh0000;
        from_link.v = 16'sh0000;
      end
    endcase
  endfunction : from_link

  // Byte address of a register index
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    addr_of = {2'b00, idx, 2'b00};
  endfunction : addr_of

  // Software configuration and PWM update counter
  logic        single_shunt_q;  // 1: one link shunt, 0: leg shunts
  logic [11:0] offset_u_q;      // U-leg or link offset
  logic [11:0] offset_v_q;      // V-leg offset
  logic [15:0] gain_q;          // ADC gain, Q12
  logic [15:0] cycles_q;        // Count of PWM updates, wraps

  // Results and datapath
  meas_pkg::results_t    res_q;     // Published values
  meas_pkg::phase_pair_t pair_d;    // Reconstructed U and V
  logic signed [15:0]    comp_a;    // Compensated sample A
  logic signed [15:0]    comp_b;    // Compensated sample B
  logic signed [15:0]    w_d;       // Derived phase W
  logic signed [15:0]    beta_d;    // Clarke beta
  logic                  valid_q;   // Update pulse

  // APB decode
  logic        access;    // Access phase, answer not yet given
  logic        done;      // Handshake edge
  logic [31:0] rdata_d;   // Read mux
  logic        mapped_d;  // Address hits a register
  logic        wr_ok;     // Write that takes effect

  // Offset and gain compensation; link mode uses one offset for both samples
  always_comb begin
    comp_a = compensate(SHUNT_A_I, offset_u_q, gain_q);
    comp_b = compensate(SHUNT_B_I, single_shunt_q ? offset_u_q : offset_v_q, gain_q);
  end

  // Phase reconstruction, W and Clarke beta in one combinational step
  always_comb begin
    if (single_shunt_q) begin
      pair_d = from_link(comp_a, comp_b, SECTOR_I);
    end else begin
      pair_d.u = comp_a;
      pair_d.v = comp_b;
    end
    w_d    = sat_cur(-(32'(pair_d.u) + 32'(pair_d.v)));
    beta_d = sat_cur(((32'(pair_d.u) + 2 * 32'(pair_d.v)) * meas_pkg::INV_SQRT3_Q15)
                     >>> meas_pkg::CLARKE_FRAC);
  end

  // Results all refresh together on the PWM strobe, so a read never mixes cycles
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      res_q <= '0;
    end else if (PWM_SYNC_I) begin
      res_q.phase_u <= pair_d.u;
      res_q.phase_v <= pair_d.v;
      res_q.phase_w <= w_d;
      res_q.alpha   <= pair_d.u;
      res_q.beta    <= beta_d;
      res_q.vdc     <= 16'(VDC_ADC_I) & meas_pkg::VDC_MAX;
    end
  end

  // Update pulse and cycle counter
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      valid_q  <= 1'b0;
      cycles_q <= 16'h0000;
    end else begin
      valid_q <= PWM_SYNC_I;
      if (PWM_SYNC_I) begin
        cycles_q <= cycles_q + 16'h0001;
      end
    end
  end

  // APB: one wait state so that ready and data leave flip-flops
  assign access = PSEL_I && PENABLE_I && !PREADY_O;
  assign done   = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_ok  = done && PWRITE_I && !PSLVERR_O;

  // Read mux; narrow values sit in the low bits, upper bits zero, not sign-extended
  always_comb begin
    rdata_d  = 32'h0000_0000;
    mapped_d = 1'b1;
    unique case (PADDR_I)
      addr_of(meas_pkg::IDX_PHASE_U):  rdata_d = {16'h0000, res_q.phase_u};
      addr_of(meas_pkg::IDX_PHASE_V):  rdata_d = {16'h0000, res_q.phase_v};
      addr_of(meas_pkg::IDX_PHASE_W):  rdata_d = {16'h0000, res_q.phase_w};
      addr_of(meas_pkg::IDX_ALPHA):    rdata_d = {16'h0000, res_q.alpha};
      addr_of(meas_pkg::IDX_BETA):     rdata_d = {16'h0000, res_q.beta};
      addr_of(meas_pkg::IDX_VDC_RAW):  rdata_d = {16'h0000, res_q.vdc};
      addr_of(meas_pkg::IDX_CONFIG):   rdata_d = {31'h0000_0000, single_shunt_q};
      addr_of(meas_pkg::IDX_OFFSET_U): rdata_d = {20'h0_0000, offset_u_q};
      addr_of(meas_pkg::IDX_OFFSET_V): rdata_d = {20'h0_0000, offset_v_q};
      addr_of(meas_pkg::IDX_ADC_GAIN): rdata_d = {16'h0000, gain_q};
      addr_of(meas_pkg::IDX_CYCLES):   rdata_d = {16'h0000, cycles_q};
      default:                         mapped_d = 1'b0;
    endcase
  end

  // Answer: ready, read data and error all registered in the first access cycle
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= access;
      PSLVERR_O <= access && !mapped_d;
      if (access) begin
        PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rdata_d;
      end
    end
  end

  // Configuration writes take effect only at the handshake edge
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      single_shunt_q <= meas_pkg::CFG_RESET[meas_pkg::CFG_SINGLE_BIT];
      offset_u_q     <= meas_pkg::OFFSET_RESET;
      offset_v_q     <= meas_pkg::OFFSET_RESET;
      gain_q         <= meas_pkg::GAIN_RESET;
    end else if (wr_ok) begin
      // Result registers ignore writes; they are read-only
      if (PADDR_I == addr_of(meas_pkg::IDX_CONFIG)) begin
        single_shunt_q <= PWDATA_I[meas_pkg::CFG_SINGLE_BIT];
      end
      if (PADDR_I == addr_of(meas_pkg::IDX_OFFSET_U)) begin
        offset_u_q <= PWDATA_I[11:0];
      end
      if (PADDR_I == addr_of(meas_pkg::IDX_OFFSET_V)) begin
        offset_v_q <= PWDATA_I[11:0];
      end
      if (PADDR_I == addr_of(meas_pkg::IDX_ADC_GAIN)) begin
        gain_q <= PWDATA_I[15:0];
      end
    end
  end

  // Update pulse leaves a flip-flop
  assign RESULT_VALID_O = valid_q;

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Leg mode, unity gain: phase U is the offset-free U sample
  a_u_leg_path: assert property (
    PWM_SYNC_I && !single_shunt_q && gain_q == meas_pkg::GAIN_RESET |=>
      32'(res_q.phase_u) == 32'($past(sat_cur(32'(SHUNT_A_I) - 32'(offset_u_q)))))
    else $error("phase U does not follow U sample");

  // Single shunt sector 6: V is the negated second sample
  a_v_link_path: assert property (
    PWM_SYNC_I && single_shunt_q && SECTOR_I == 3'd6 |=>
      32'(res_q.phase_v) == 32'($past(sat_cur(-32'(comp_b)))))
    else $error("phase V wrong in single shunt sector 6");

  // A sample equal to its offset reads as zero current
  a_offset_zero: assert property (
    PWM_SYNC_I && !single_shunt_q && 12'(SHUNT_A_I) == offset_u_q |=>
      res_q.phase_u == 16'sh0000)
    else $error("offset not removed");

  // W balances U and V unless clamped
  a_w_balance: assert property (
    $rose(valid_q) && res_q.phase_w != meas_pkg::CUR_MAX && res_q.phase_w != meas_pkg::CUR_MIN
      |-> 32'(res_q.phase_u) + 32'(res_q.phase_v) + 32'(res_q.phase_w) == 0)
    else $error("phase W not minus U plus V");

  // Alpha equals phase U after every update
  a_alpha_eq_u: assert property (
    valid_q |-> res_q.alpha == res_q.phase_u)
    else $error("alpha differs from phase U");

  // Beta sign follows U plus twice V; a sum of one floors to zero, hence the inclusive test
  sequence s_update;
    PWM_SYNC_I ##1 valid_q;
  endsequence
  a_beta_sign: assert property (
    s_update |-> ((32'(res_q.phase_u) + 2 * 32'(res_q.phase_v)) >= 0) == (res_q.beta >= 0))
    else $error("beta sign wrong");

  // Currents within range at all times
  a_cur_range: assert property (
    res_q.phase_u <= meas_pkg::CUR_MAX && res_q.phase_u >= meas_pkg::CUR_MIN &&
    res_q.phase_v <= meas_pkg::CUR_MAX && res_q.phase_v >= meas_pkg::CUR_MIN &&
    res_q.alpha <= meas_pkg::CUR_MAX && res_q.alpha >= meas_pkg::CUR_MIN &&
    res_q.phase_w <= meas_pkg::CUR_MAX && res_q.phase_w >= meas_pkg::CUR_MIN &&
    res_q.beta <= meas_pkg::CUR_MAX && res_q.beta >= meas_pkg::CUR_MIN)
    else $error("current out of range");

  // Bus voltage follows the sample, holds between strobes
  sequence s_strobe_quiet;
    PWM_SYNC_I ##1 (!PWM_SYNC_I)[*2];
  endsequence
  a_vdc_sample: assert property (
    s_strobe_quiet |-> res_q.vdc == 16'($past(VDC_ADC_I, 2)) &&
      res_q.vdc <= meas_pkg::VDC_MAX)
    else $error("bus voltage not sampled or held");

  // Ready is high for exactly one cycle per access
  sequence s_apb_wait;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  a_apb_ready: assert property (
    s_apb_wait |=> PREADY_O ##1 !PREADY_O)
    else $error("ready not a single-cycle answer");

  // An unmapped address answers with an error and zero data
  a_apb_error: assert property (
    s_apb_wait && !mapped_d |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Without a select the slave never answers
  a_idle_ready: assert property (
    !PSEL_I |=> !PREADY_O)
    else $error("ready without a select");

  // Leg mode, unity gain: phase V is the offset-free V sample
  a_v_leg_path: assert property (
    PWM_SYNC_I && !single_shunt_q && gain_q == meas_pkg::GAIN_RESET |=>
      32'(res_q.phase_v) == 32'($past(sat_cur(32'(SHUNT_B_I) - 32'(offset_v_q)))))
    else $error("phase V does not follow V sample");

  // An illegal sector in link mode reads as zero, not as a wrong phase
  a_bad_sector: assert property (
    PWM_SYNC_I && single_shunt_q && (SECTOR_I == 3'd0 || SECTOR_I == 3'd7) |=>
      res_q.phase_u == 16'sh0000 && res_q.phase_v == 16'sh0000)
    else $error("illegal sector gave nonzero phase current");

  // Results change only on a strobe, so a read never sees a half update
  a_result_hold: assert property (
    !PWM_SYNC_I |=> $stable(res_q))
    else $error("results changed without a strobe");

  // The update pulse follows each strobe by one cycle and lasts as long as the strobe
  a_valid_pulse: assert property (
    RESULT_VALID_O == $past(PWM_SYNC_I))
    else $error("update pulse not one cycle after strobe");

  // A gain write lands in the gain register at the handshake edge
  a_gain_write: assert property (
    wr_ok && PADDR_I == addr_of(meas_pkg::IDX_ADC_GAIN) |=>
      gain_q == $past(PWDATA_I[15:0]))
    else $error("gain write lost");

endmodule : phase_meas

// File: verif/adc_model.sv
// Behavioural model of the shunt ADCs, the bus voltage ADC and the PWM strobe.
// Assumes the bench raises fire_i for one cycle on the same clock.
`timescale 1ns/1ps
module adc_model (
  // Clock, reset and request from the bench
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        fire_i,
  input  wire logic [11:0] a_i,
  input  wire logic [11:0] b_i,
  input  wire logic [11:0] v_i,
  input  wire logic [2:0]  sec_i,
  // Towards the block
  output logic             sync_o,
  output logic [11:0]      sh_a_o,
  output logic [11:0]      sh_b_o,
  output logic [11:0]      vdc_o,
  output logic [2:0]       sec_o
);
  // Samples are valid only with the strobe; between strobes they toggle
  // every cycle, so a block sampling off the strobe reads garbage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_o <= 1'b0;
      sh_a_o <= 12'h000;
      sh_b_o <= 12'h000;
      vdc_o  <= 12'h000;
      sec_o  <= 3'h0;
    end else if (fire_i) begin
      sync_o <= 1'b1;
      sh_a_o <= a_i;
      sh_b_o <= b_i;
      vdc_o  <= v_i;
      sec_o  <= sec_i;
    end else begin
      sync_o <= 1'b0;
      sh_a_o <= ~sh_a_o;
      sh_b_o <= ~sh_b_o;
      vdc_o  <= ~vdc_o;
      sec_o  <= ~sec_o;
    end
  end
endmodule : adc_model

// File: verif/testbench.sv
// Self-checking bench for the phase current and bus voltage block.
// Assumes a 4 ns clock; the APB master waits for ready as long as it takes.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;      // Reference clock
  logic        rst_n = 1'b0;    // Reset, active low
  logic        psel = 1'b0;     // APB request
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;          // APB answer
  logic        pready;
  logic        pslverr;
  logic        fire = 1'b0;     // Strobe request to the model
  logic [11:0] ra = 12'h000;
  logic [11:0] rb = 12'h000;
  logic [11:0] rv = 12'h000;
  logic [2:0]  rs = 3'h0;
  logic        sync;            // Model outputs
  logic [11:0] sha;
  logic [11:0] shb;
  logic [11:0] vdc;
  logic [2:0]  sec;
  logic        valid;
  logic [32:0] q[$];            // Expected read answers, oldest first
  logic [32:0] exp_r;
  logic [31:0] st = 32'h9116_bee5;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n_fire = 0;      // Strobes sent, for the counter
  int          offu = 0;        // Bench copies of the settings
  int          offv = 0;
  int          gain = 4096;
  int          single = 0;
  int          usel[6] = '{0, 1, 2, 2, 1, 0};
  int          vsel[6] = '{1, 0, 0, 1, 2, 2};

  always #2 clk = ~clk;

  adc_model i_adc (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .a_i(ra), .b_i(rb),
    .v_i(rv), .sec_i(rs), .sync_o(sync), .sh_a_o(sha), .sh_b_o(shb), .vdc_o(vdc),
    .sec_o(sec));

  phase_meas i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PWM_SYNC_I(sync), .SECTOR_I(sec),
    .SHUNT_A_I(sha), .SHUNT_B_I(shb), .VDC_ADC_I(vdc), .RESULT_VALID_O(valid));

  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : xs

  function automatic int clamp(int x);
    return (x > 2047) ? 2047 : ((x < -2047) ? -2047 : x);
  endfunction : clamp

  // Offset removal then gain compensation, saturated
  function automatic int sc(int raw, int off);
    return clamp(((raw - off) * gain) >>> 12);
  endfunction : sc

  function automatic int pick(int k, int a, int b);
    return (k == 0) ? a : ((k == 1) ? b - a : -b);
  endfunction : pick

  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // One APB transfer; a read leaves its expected answer on the queue
  task automatic apb(input logic w, input logic [7:0] idx, input int d, input logic [32:0] e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    if (!w)
      q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    // Only the hang guard ends a wait for ready
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] idx, input int v);
    apb(1'b0, idx, 0, {17'h0_0000, v[15:0]});
  endtask : rd

  task automatic wr(input logic [7:0] idx, input int d);
    apb(1'b1, idx, d, 33'h0_0000_0000);
  endtask : wr

  // Strobe one sample set through the model, then read every result
  task automatic meas(input int a, input int b, input int v, input int s);
    int ua;
    int ub;
    int u;
    int w;
    ua = sc(a, offu);
    ub = sc(b, single ? offu : offv);
    u  = (single == 0) ? ua : ((s < 1 || s > 6) ? 0 : clamp(pick(usel[s-1], ua, ub)));
    w  = (single == 0) ? ub : ((s < 1 || s > 6) ? 0 : clamp(pick(vsel[s-1], ua, ub)));
    n_fire++;
    @(posedge clk);
    fire <= 1'b1;
    ra   <= a[11:0];
    rb   <= b[11:0];
    rv   <= v[11:0];
    rs   <= s[2:0];
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    #1 chk("valid", {32'h0000_0000, valid}, 33'h0_0000_0001);
    @(posedge clk);
    #1 chk("valid low", {32'h0000_0000, valid}, 33'h0_0000_0000);
    // Writes to results must be ignored
    wr(meas_pkg::IDX_PHASE_U, xs());
    rd(meas_pkg::IDX_PHASE_U, u);
    rd(meas_pkg::IDX_PHASE_V, w);
    rd(meas_pkg::IDX_PHASE_W, clamp(-(u + w)));
    rd(meas_pkg::IDX_ALPHA, u);
    rd(meas_pkg::IDX_BETA, clamp(((u + 2 * w) * 18919) >>> 15));
    rd(meas_pkg::IDX_VDC_RAW, v);
  endtask : meas

  // Read monitor: every answered read is matched to the oldest note
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      exp_r = (q.size() > 0) ? q.pop_front() : 33'h1_ffff_ffff;
      chk("read", {pslverr, prdata}, exp_r);
    end
  end

  // Hang guard, far above the roughly nine hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then an unmapped place
    rd(meas_pkg::IDX_PHASE_U, 0);
    rd(meas_pkg::IDX_BETA, 0);
    rd(meas_pkg::IDX_VDC_RAW, 0);
    rd(meas_pkg::IDX_ADC_GAIN, 4096);
    apb(1'b0, 8'hff, 0, 33'h1_0000_0000);
    // Leg shunts with random offsets; unity gain for the first four, random gains after
    for (int i = 0; i < 12; i++) begin
      offu = xs() % 400;
      offv = xs() % 400;
      gain = (i < 4) ? 4096 : 2048 + xs() % 14336;
      wr(meas_pkg::IDX_OFFSET_U, offu);
      wr(meas_pkg::IDX_OFFSET_V, offv);
      wr(meas_pkg::IDX_ADC_GAIN, gain);
      meas(xs() % 4096, xs() % 4096, xs() % 4096, xs() % 8);
    end
    // A sample equal to its offset reads as zero current
    meas(offu, xs() % 4096, xs() % 4096, 0);
    // Full-scale samples saturate at the limits
    offu = 0;
    offv = 0;
    gain = 8192;
    wr(meas_pkg::IDX_OFFSET_U, offu);
    wr(meas_pkg::IDX_OFFSET_V, offv);
    wr(meas_pkg::IDX_ADC_GAIN, gain);
    meas(4095, 0, 4095, 0);
    // Single link shunt through every sector code
    single = 1;
    offu = 100;
    gain = 4096;
    wr(meas_pkg::IDX_CONFIG, 1);
    wr(meas_pkg::IDX_OFFSET_U, offu);
    wr(meas_pkg::IDX_ADC_GAIN, gain);
    for (int s = 0; s < 8; s++)
      meas(100 + xs() % 1500, 100 + xs() % 1500, xs() % 4096, s);
    rd(meas_pkg::IDX_CYCLES, n_fire);
    repeat (4) @(posedge clk);
    chk("queue", 33'(q.size()), 33'h0_0000_0000);
    summarize();
  end
endmodule : testbench
